// >>> aor_defines.svh
// Purpose: Offsets, field positions, channel numbers and timing counts.
// Assumes: Converter clock of 250 MHz drives all logic.
// Notes:   Included by its bare name.
`ifndef AOR_DEFINES_SVH
`define AOR_DEFINES_SVH

// Register offsets.
`define AOR_ADDR_STAT   8'h00
`define AOR_ADDR_CTL1   8'h04
`define AOR_ADDR_OVS    8'h08
`define AOR_ADDR_DATA   8'h0c

// Status fields.
`define AOR_STAT_EOC    1
`define AOR_STAT_RUN    4

// Control one fields.
`define AOR_CTL1_ON     0
`define AOR_CTL1_START  1
`define AOR_CTL1_CH_LO  8
`define AOR_CTL1_CH_HI  12
`define AOR_CTL1_TSVR   23

// Oversample control fields.
`define AOR_OVS_EN      0
`define AOR_OVS_RAT_LO  2
`define AOR_OVS_RAT_HI  4
`define AOR_OVS_SH_LO   5
`define AOR_OVS_SH_HI   8
`define AOR_OVS_RES_LO  12
`define AOR_OVS_RES_HI  13

// Internal channel numbers.
`define AOR_CH_TEMP     5'h10
`define AOR_CH_VREF     5'h11

// Largest shift and accumulator width.
`define AOR_SHIFT_MAX   4'h8
`define AOR_ACC_W       20

// Phase lengths in half converter clock cycles.
`define AOR_SMPL_HALF   3
`define AOR_CONV12_HALF 25
`define AOR_CONV10_HALF 21
`define AOR_CONV8_HALF  17
`define AOR_CONV6_HALF  13
// Whole cycles: sampling rounds up, totals are exact.
`define AOR_SMPL_CYC    ((`AOR_SMPL_HALF + 1) / 2)
`define AOR_TADC12      ((`AOR_SMPL_HALF + `AOR_CONV12_HALF) / 2)
`define AOR_TADC10      ((`AOR_SMPL_HALF + `AOR_CONV10_HALF) / 2)
`define AOR_TADC8       ((`AOR_SMPL_HALF + `AOR_CONV8_HALF) / 2)
`define AOR_TADC6       ((`AOR_SMPL_HALF + `AOR_CONV6_HALF) / 2)

`endif

// >>> aor_pkg.sv
// Purpose: Types shared by the converter control files.
// Assumes: Nothing beyond the defines header.
// Notes:   Codes are written out.
package aor_pkg;

  typedef enum logic [1:0] {
    AOR_RES_12 = 2'b00,
    AOR_RES_10 = 2'b01,
    AOR_RES_8  = 2'b10,
    AOR_RES_6  = 2'b11
  } aor_res_t;

  typedef enum logic [2:0] {
    AOR_T_IDLE = 3'b001,
    AOR_T_SMPL = 3'b010,
    AOR_T_CONV = 3'b100
  } aor_tstate_t;

endpackage : aor_pkg

// >>> aor_conv_timer.sv
// Purpose: Sampling and approximation phase timing of one conversion.
// Assumes: start_i is only raised while idle_o is high.
// Notes:   Resolution is latched at start and held for the conversion.
`timescale 1ns/10ps
`include "aor_defines.svh"

module aor_conv_timer (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  // Control
  input  wire logic              start_i,
  input  wire aor_pkg::aor_res_t res_i,
  // Phase outputs
  output logic                   idle_o,
  output logic                   sample_o,
  output logic                   convert_o,
  output logic                   done_o
);

  aor_pkg::aor_tstate_t state_reg;
  aor_pkg::aor_tstate_t state_next;
  aor_pkg::aor_res_t    res_reg;
  logic [4:0]           cnt_reg;
  logic [4:0]           total;
  wire                  last_cyc;
  wire                  smpl_end;

  ////////////////////////////////////////////////////////////////////////////
  // cycle totals
  always_comb
  begin
    unique case (res_reg)
      aor_pkg::AOR_RES_12: total = 5'(`AOR_TADC12);
      aor_pkg::AOR_RES_10: total = 5'(`AOR_TADC10);
      aor_pkg::AOR_RES_8:  total = 5'(`AOR_TADC8);
      aor_pkg::AOR_RES_6:  total = 5'(`AOR_TADC6);
    endcase
  end

  assign smpl_end = cnt_reg == 5'(`AOR_SMPL_CYC - 1);
  assign last_cyc = cnt_reg == total - 5'h01;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      aor_pkg::AOR_T_IDLE: if (start_i) state_next = aor_pkg::AOR_T_SMPL;
      aor_pkg::AOR_T_SMPL: if (smpl_end) state_next = aor_pkg::AOR_T_CONV;
      aor_pkg::AOR_T_CONV: if (last_cyc) state_next = aor_pkg::AOR_T_IDLE;
      default:             state_next = aor_pkg::AOR_T_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= aor_pkg::AOR_T_IDLE;
      res_reg   <= aor_pkg::AOR_RES_12;
      cnt_reg   <= 5'h00;
      done_o    <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      done_o    <= (state_reg == aor_pkg::AOR_T_CONV) && last_cyc;
      cnt_reg   <= (state_reg == aor_pkg::AOR_T_IDLE) ? 5'h00
                                                      : cnt_reg + 5'h01;
      if (state_reg == aor_pkg::AOR_T_IDLE && start_i)
        res_reg <= res_i;
    end
  end

  assign idle_o    = state_reg[0];
  assign sample_o  = state_reg[1];
  assign convert_o = state_reg[2];

endmodule : aor_conv_timer

// >>> aor_oversampler.sv
// Purpose: Sums N results, shifts with rounding, keeps 16 bits.
// Assumes: One data_valid_i pulse per finished conversion.
// Notes:   With oversampling off each result passes straight through.
`timescale 1ns/10ps
`include "aor_defines.svh"

module aor_oversampler #(
  parameter int ACC_W = `AOR_ACC_W
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Settings
  input  wire logic        enable_i,
  input  wire logic [2:0]  ratio_i,
  input  wire logic [3:0]  shift_i,
  // Conversion results
  input  wire logic        data_valid_i,
  input  wire logic [11:0] data_i,
  // Averaged output
  output logic             last_o,
  output logic             result_valid_o,
  output logic [15:0]      result_o
);

  logic [ACC_W-1:0] acc_reg;
  logic [8:0]       cnt_reg;
  wire  [8:0]       ratio_n;
  wire  [ACC_W:0]   sum;
  wire  [3:0]       sh;
  wire  [ACC_W:0]   half;
  wire  [ACC_W:0]   rounded;
  wire              deliver;

  ////////////////////////////////////////////////////////////////////////////
  // ratio decode
  assign ratio_n = 9'h002 << ratio_i;
  assign sum     = {1'b0, acc_reg} + (ACC_W+1)'(data_i);
  assign sh      = (shift_i > `AOR_SHIFT_MAX) ? `AOR_SHIFT_MAX : shift_i;
  assign half    = (sh == 4'h0) ? '0 : ((ACC_W+1)'(1) << (sh - 4'h1));
  assign rounded = (sum + half) >> sh;
  assign last_o  = !enable_i || (cnt_reg == ratio_n - 9'h001);
  assign deliver = data_valid_i && last_o;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc_reg        <= '0;
      cnt_reg        <= 9'h000;
      result_valid_o <= 1'b0;
      result_o       <= 16'h0000;
    end
    else
    begin
      result_valid_o <= deliver;
      if (!enable_i || deliver)
      begin
        acc_reg <= '0;
        cnt_reg <= 9'h000;
      end
      else if (data_valid_i)
      begin
        acc_reg <= sum[ACC_W-1:0];
        cnt_reg <= cnt_reg + 9'h001;
      end
      if (deliver)
        result_o <= enable_i ? rounded[15:0] : {4'h0, data_i};
    end
  end

endmodule : aor_oversampler

// >>> aor_converter_ctrl.sv
// Purpose: Register front end, internal channels, resolution and
//          oversampling control around the approximation core.
// Assumes: Software keeps the resolution fixed while the converter is on;
//          a write during that time is ignored for safety.
// Notes:   Read data stands in the cycle after the read strobe only.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/10ps
`include "aor_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module aor_converter_ctrl (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Start trigger
  input  wire logic        trigger_i,
  // Approximation core
  input  wire logic [11:0] core_result_i,
  output logic             core_sample_o,
  output logic             core_convert_o,
  output logic [1:0]       core_res_o,
  output logic [4:0]       core_channel_o,
  // Internal analog channels
  output logic             temp_sensor_input_en_o,
  output logic             internal_ref_input_en_o,
  output logic             temp_sensor_pd_o,
  // Status
  output logic             eoc_o
);

  // Control one fields.
  logic              converter_on_reg;
  logic              sensor_ref_enable_reg;
  logic [4:0]        channel_reg;
  // Oversample control fields.
  logic              ovs_en_reg;
  logic [2:0]        oversample_ratio_reg;
  logic [3:0]        oversample_shift_reg;
  aor_pkg::aor_res_t resolution_select_reg;
  // Run state and results.
  logic              run_reg;
  logic              eoc_reg;
  logic [15:0]       data_reg;

  wire               wr_stat;
  wire               wr_ctl1;
  wire               wr_ovs;
  wire               rd_data;
  wire               sw_start;
  wire               start_req;
  wire               tim_idle;
  wire               tim_done;
  wire               tim_sample;
  wire               tim_convert;
  wire               tim_start;
  wire               ovs_last;
  wire               ovs_valid;
  wire [15:0]        ovs_result;
  wire [11:0]        masked;
  wire               internal_ch;
  wire               chan_ok;
  wire [4:0]         chan_sel;
  wire               tsvr_sel;
  wire [31:0]        stat_word;
  wire [31:0]        ctl1_word;
  wire [31:0]        ovs_word;
  wire [31:0]        data_word;
  logic [31:0]       rd_mux;
  logic [11:0]       res_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.
  assign wr_stat = wr_i && (addr_i == `AOR_ADDR_STAT);
  assign wr_ctl1 = wr_i && (addr_i == `AOR_ADDR_CTL1);
  assign wr_ovs  = wr_i && (addr_i == `AOR_ADDR_OVS);
  assign rd_data = rd_i && (addr_i == `AOR_ADDR_DATA);

  assign sw_start = wr_ctl1 && wdata_i[`AOR_CTL1_START]
                  && wdata_i[`AOR_CTL1_ON];
  assign start_req = converter_on_reg && !run_reg && trigger_i;

  // internal channel gating
  // A start written with a new channel is judged on the written values.
  assign chan_sel    = wr_ctl1 ? wdata_i[`AOR_CTL1_CH_HI:`AOR_CTL1_CH_LO]
                               : channel_reg;
  assign tsvr_sel    = wr_ctl1 ? wdata_i[`AOR_CTL1_TSVR]
                               : sensor_ref_enable_reg;
  assign internal_ch = (chan_sel == `AOR_CH_TEMP)
                     || (chan_sel == `AOR_CH_VREF);
  assign chan_ok     = !internal_ch || tsvr_sel;

  // Timer is restarted back to back until the oversampler has its N.
  // The last done must not launch a stray conversion into the next sum.
  assign tim_start = run_reg && tim_idle && !(tim_done && ovs_last);

  ////////////////////////////////////////////////////////////////////////////
  // Results above the selected width are masked so a noisy core cannot
  // leak stray low-resolution bits into the sum.
  always_comb
  begin
    unique case (resolution_select_reg)
      aor_pkg::AOR_RES_12: res_mask = 12'hfff;
      aor_pkg::AOR_RES_10: res_mask = 12'h3ff;
      aor_pkg::AOR_RES_8:  res_mask = 12'h0ff;
      aor_pkg::AOR_RES_6:  res_mask = 12'h03f;
    endcase
  end

  assign masked = core_result_i & res_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Read words.
  assign stat_word = {27'h0, run_reg, 2'h0, eoc_reg, 1'b0};
  assign ctl1_word = {8'h00, sensor_ref_enable_reg, 10'h000, channel_reg,
                      7'h00, converter_on_reg};
  assign ovs_word  = {18'h00000, resolution_select_reg, 3'h0,
                      oversample_shift_reg, oversample_ratio_reg, 1'b0,
                      ovs_en_reg};
  assign data_word = {16'h0000, data_reg};

  always_comb
  begin
    unique case (addr_i)
      `AOR_ADDR_STAT: rd_mux = stat_word;
      `AOR_ADDR_CTL1: rd_mux = ctl1_word;
      `AOR_ADDR_OVS:  rd_mux = ovs_word;
      `AOR_ADDR_DATA: rd_mux = data_word;
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase timing per resolution.
  aor_conv_timer u_timer (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .start_i   (tim_start),
    .res_i     (resolution_select_reg),
    .idle_o    (tim_idle),
    .sample_o  (tim_sample),
    .convert_o (tim_convert),
    .done_o    (tim_done)
  );

  // Averaging of successive results.
  aor_oversampler #(
    .ACC_W (`AOR_ACC_W)
  ) u_ovs (
    .clock_i        (clock_i),
    .rst_n_i        (rst_n_i),
    .enable_i       (ovs_en_reg),
    .ratio_i        (oversample_ratio_reg),
    .shift_i        (oversample_shift_reg),
    .data_valid_i   (tim_done),
    .data_i         (masked),
    .last_o         (ovs_last),
    .result_valid_o (ovs_valid),
    .result_o       (ovs_result)
  );

  assign core_sample_o  = tim_sample;
  assign core_convert_o = tim_convert;

  ////////////////////////////////////////////////////////////////////////////
  // Control one register.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      converter_on_reg      <= 1'b0;
      sensor_ref_enable_reg <= 1'b0;
      channel_reg           <= 5'h00;
    end
    else if (wr_ctl1)
    begin
      converter_on_reg      <= wdata_i[`AOR_CTL1_ON];
      sensor_ref_enable_reg <= wdata_i[`AOR_CTL1_TSVR];
      channel_reg           <= wdata_i[`AOR_CTL1_CH_HI:`AOR_CTL1_CH_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oversample control register.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ovs_en_reg            <= 1'b0;
      oversample_ratio_reg  <= 3'h0;
      oversample_shift_reg  <= 4'h0;
      resolution_select_reg <= aor_pkg::AOR_RES_12;
    end
    else if (wr_ovs)
    begin
      ovs_en_reg           <= wdata_i[`AOR_OVS_EN];
      oversample_ratio_reg <= wdata_i[`AOR_OVS_RAT_HI:`AOR_OVS_RAT_LO];
      oversample_shift_reg <= wdata_i[`AOR_OVS_SH_HI:`AOR_OVS_SH_LO];
      if (!converter_on_reg)
        resolution_select_reg <= aor_pkg::aor_res_t'(
          wdata_i[`AOR_OVS_RES_HI:`AOR_OVS_RES_LO]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run control, result and end flag.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      run_reg  <= 1'b0;
      eoc_reg  <= 1'b0;
      data_reg <= 16'h0000;
    end
    else
    begin
      if (!run_reg && chan_ok && (sw_start || start_req))
        run_reg <= 1'b1;
      else if (tim_done && ovs_last)
        run_reg <= 1'b0;
      if (ovs_valid)
        data_reg <= ovs_result;
      if (ovs_valid)
        eoc_reg <= 1'b1;
      else if (rd_data || (wr_stat && !wdata_i[`AOR_STAT_EOC]))
        eoc_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the core and analog side.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o                 <= 32'h0000_0000;
      core_res_o              <= 2'b00;
      core_channel_o          <= 5'h00;
      temp_sensor_input_en_o  <= 1'b0;
      internal_ref_input_en_o <= 1'b0;
      temp_sensor_pd_o        <= 1'b1;
      eoc_o                   <= 1'b0;
    end
    else
    begin
      rdata_o                 <= rd_i ? rd_mux : 32'h0000_0000;
      core_res_o              <= resolution_select_reg;
      core_channel_o          <= channel_reg;
      temp_sensor_input_en_o  <= sensor_ref_enable_reg;
      internal_ref_input_en_o <= sensor_ref_enable_reg;
      temp_sensor_pd_o        <= !sensor_ref_enable_reg;
      eoc_o                   <= eoc_reg;
    end
  end

endmodule : aor_converter_ctrl

// >>> aor_ctrl_sva.sv
// Purpose: Concurrent checks on the converter control ports.
// Assumes: One clock domain; reset asynchronous, active low.
// Notes:   Bound to the control top after the module.
`timescale 1ns/10ps
`include "aor_defines.svh"

module aor_ctrl_sva (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  // Register port
  input wire logic [7:0]  addr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // Core side
  input wire logic        core_sample_o,
  input wire logic        core_convert_o,
  input wire logic [1:0]  core_res_o,
  input wire logic [4:0]  core_channel_o,
  // Channels and status
  input wire logic        temp_sensor_input_en_o,
  input wire logic        internal_ref_input_en_o,
  input wire logic        temp_sensor_pd_o,
  input wire logic        eoc_o
);
  logic [3:0] cv_cnt_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // A counter is used since the phase length depends on the resolution.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cv_cnt_reg <= 4'h0;
    else if (core_convert_o)
      cv_cnt_reg <= cv_cnt_reg + 4'h1;
    else
      cv_cnt_reg <= 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence samp_two;
    core_sample_o ##1 core_sample_o;
  endsequence

  sequence into_conv;
    !core_sample_o && core_convert_o;
  endsequence

  samp_len_a:
    assert property ($rose(core_sample_o) |-> samp_two ##1 into_conv)
    else $error("sampling phase length wrong");
  conv_len_a:
    assert property ($fell(core_convert_o) |->
      cv_cnt_reg == 4'hc - {1'b0, core_res_o, 1'b0})
    else $error("approximation phase length wrong");
  phase_excl_a:
    assert property (!(core_sample_o && core_convert_o))
    else $error("sampling and approximation overlap");
  res_hold_a:
    assert property (core_convert_o |-> $stable(core_res_o))
    else $error("resolution moved during a conversion");
  pd_inverse_a:
    assert property (temp_sensor_pd_o == !temp_sensor_input_en_o)
    else $error("sensor power down not inverse of enable");
  ref_pair_a:
    assert property (internal_ref_input_en_o == temp_sensor_input_en_o)
    else $error("reference channel not paired with sensor");
  chan_gate_a:
    assert property ($rose(core_sample_o) && core_channel_o[4:1] == 4'h8
      |-> temp_sensor_input_en_o)
    else $error("internal channel converted while disabled");
  eoc_rise_a:
    assert property ($rose(eoc_o) |->
      $past(core_convert_o, 4) && !$past(core_convert_o, 3))
    else $error("end flag not tied to conversion end");
  eoc_clear_a:
    assert property (rd_i && addr_i == `AOR_ADDR_DATA &&
      !$past(core_convert_o, 2) |-> ##2 !eoc_o)
    else $error("end flag not cleared by data read");
  rdata_idle_a:
    assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data present without a read");
endmodule : aor_ctrl_sva

bind aor_converter_ctrl aor_ctrl_sva aor_ctrl_sva_i (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .core_sample_o(core_sample_o),
  .core_convert_o(core_convert_o), .core_res_o(core_res_o),
  .core_channel_o(core_channel_o),
  .temp_sensor_input_en_o(temp_sensor_input_en_o),
  .internal_ref_input_en_o(internal_ref_input_en_o),
  .temp_sensor_pd_o(temp_sensor_pd_o), .eoc_o(eoc_o));

// >>> aor_core_model.sv
// Purpose: Behavioural approximation core answering the control block.
// Assumes: Result is taken in the cycle after the last approximation cycle.
// Notes:   Outside that span the inverse value shows, so no stale match.
`timescale 1ns/10ps

module aor_core_model (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Control side
  input  wire logic        convert_i,
  input  wire logic [11:0] value_i,
  output logic      [11:0] result_o
);
  logic conv_d_reg;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      conv_d_reg <= 1'b0;
    else
      conv_d_reg <= convert_i;
  end

  assign result_o = (convert_i || conv_d_reg) ? value_i : ~value_i;
endmodule : aor_core_model

// >>> aor_converter_ctrl_bench.sv
// Purpose: Directed tests of the converter control through its registers.
// Assumes: Register port answers reads in the next cycle.
// Notes:   Only mismatches and the verdict are printed.
`timescale 1ns/10ps
`include "aor_defines.svh"

module aor_converter_ctrl_bench;
  logic        clock_i, rst_n_i, wr_i, rd_i, trigger_i, eoc_o, samp_d;
  logic        core_sample_o, core_convert_o, ten, ren, pd;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, rd_val;
  logic [11:0] core_result_i, core_val;
  logic [1:0]  core_res_o;
  logic [4:0]  core_channel_o;
  logic [19:0] sum;
  logic [15:0] expv;
  int          n_mismatch, cmp_count, busy_cnt, samp_cnt, b0, r, s;

  aor_converter_ctrl aor_converter_ctrl_i (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .trigger_i(trigger_i),
    .core_result_i(core_result_i), .core_sample_o(core_sample_o),
    .core_convert_o(core_convert_o), .core_res_o(core_res_o),
    .core_channel_o(core_channel_o), .temp_sensor_input_en_o(ten),
    .internal_ref_input_en_o(ren), .temp_sensor_pd_o(pd), .eoc_o(eoc_o));
  aor_core_model aor_core_model_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .convert_i(core_convert_o), .value_i(core_val),
    .result_o(core_result_i));

  always #2 clock_i = ~clock_i;

  always @(posedge clock_i)
  begin
    busy_cnt += int'(core_sample_o | core_convert_o);
    samp_cnt += int'(core_sample_o & ~samp_d);
    samp_d = core_sample_o;
  end

  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [7:0] a);
    @(posedge clock_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1;
    rd_val = rdata_o;
  endtask : rd_reg

  // Bounded wait; a hang shows as a missing end flag.
  task wait_eoc;
    int k;
    k = 0;
    while (eoc_o !== 1'b1 && k < 6000)
    begin
      @(posedge clock_i);
      #1;
      k++;
    end
    chk_val({31'h0, eoc_o}, 32'h1);
  endtask : wait_eoc

  task eoc_gone;
    @(posedge clock_i);
    #1;
    chk_val({31'h0, eoc_o}, 32'h0);
  endtask : eoc_gone

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {clock_i, wr_i, rd_i, trigger_i, samp_d, rst_n_i} = 6'h00;
    n_mismatch = 0;
    cmp_count = 0;
    busy_cnt = 0;
    samp_cnt = 0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    core_val = 12'h5a3;
    repeat (12) @(posedge clock_i);
    chk_val({31'h0, pd}, 32'h1);
    rst_n_i <= 1'b1;
    rd_reg(`AOR_ADDR_CTL1);
    chk_val(rd_val, 32'h0);
    rd_reg(`AOR_ADDR_OVS);
    chk_val(rd_val, 32'h0);
    rd_reg(8'h10);
    chk_val(rd_val, 32'h0);
    wr_reg(8'h10, 32'hffff_ffff);
    wr_reg(`AOR_ADDR_CTL1, 32'h0000_1003);
    rd_reg(`AOR_ADDR_STAT);
    chk_val(rd_val, 32'h0);
    wr_reg(`AOR_ADDR_CTL1, 32'h0080_0001);
    repeat (2) @(posedge clock_i);
    #1;
    chk_val({29'h0, ten, ren, pd}, 32'h6);
    wr_reg(`AOR_ADDR_CTL1, 32'h0080_1103);
    wait_eoc();
    chk_val(32'(core_channel_o), 32'h11);
    rd_reg(`AOR_ADDR_CTL1);
    chk_val(rd_val, 32'h0080_1101);
    rd_reg(`AOR_ADDR_DATA);
    chk_val(rd_val, 32'h5a3);
    eoc_gone();
    wr_reg(`AOR_ADDR_CTL1, 32'h0000_0001);
    repeat (2) @(posedge clock_i);
    #1;
    chk_val({29'h0, ten, ren, pd}, 32'h1);
    for (int i = 0; i < 9; i++)
    begin
      r = (i == 8) ? 7 : i;
      s = (i == 8) ? 0 : i + 1;
      core_val = 12'hfff - 12'(i * 12'h1c7);
      sum = 20'(core_val) << (r + 1);
      expv = 16'((sum + ((s > 0) ? (20'h1 << (s - 1)) : 20'h0)) >> s);
      wr_reg(`AOR_ADDR_OVS, 32'h1 | 32'(r << 2) | 32'(s << 5));
      b0 = samp_cnt;
      wr_reg(`AOR_ADDR_CTL1, 32'h3);
      wait_eoc();
      chk_val(32'(samp_cnt - b0), 32'(2 << r));
      wr_reg(`AOR_ADDR_STAT, 32'h0);
      eoc_gone();
      rd_reg(`AOR_ADDR_DATA);
      chk_val(rd_val, 32'(expv));
    end
    for (int j = 0; j < 4; j++)
    begin
      wr_reg(`AOR_ADDR_CTL1, 32'h0);
      wr_reg(`AOR_ADDR_OVS, 32'(j) << 12);
      wr_reg(`AOR_ADDR_CTL1, 32'h1);
      b0 = busy_cnt;
      if (j == 3)
      begin
        @(posedge clock_i);
        trigger_i <= 1'b1;
        @(posedge clock_i);
        trigger_i <= 1'b0;
      end
      else
        wr_reg(`AOR_ADDR_CTL1, 32'h3);
      wait_eoc();
      chk_val(32'(busy_cnt - b0), 32'(14 - 2 * j));
      chk_val(32'(core_res_o), 32'(j));
      rd_reg(`AOR_ADDR_DATA);
      if (j == 0)
      begin
        chk_val(rd_val, 32'(core_val));
        wr_reg(`AOR_ADDR_OVS, 32'h1000);
        rd_reg(`AOR_ADDR_OVS);
        chk_val(rd_val, 32'h0);
      end
      eoc_gone();
    end
    close_out();
  end

  initial
  begin
    repeat (60000) @(posedge clock_i);
    n_mismatch++;
    close_out();
  end
endmodule : aor_converter_ctrl_bench
